// >>> rtl/jtp_pkg.sv
// constants and types of the boundary test port pin logic
// assumes a 125 MHz system clock that oversamples the test clock pin
//
// Overview of operation
// - test-port logic and shifting advance only on edges of the test clock; a low test reset acts without one.
// - mode select is sampled on each rising test clock edge to step the TAP.
// - data input is sampled on each rising edge into the selected register.
// - data output is driven only in the shift-IR and shift-DR states.
// - in every other state and during reset the data output is high impedance.
// - data output changes only on the falling test clock edge or under a low test reset.
// - a low test reset input resets the TAP controller.
// - a system reset alone leaves the TAP and instruction untouched; it only empties the buffer toward the core.
// - the test clock input carries an internal pull-down.
// - mode select, data input and test reset carry pull-ups that the
//      pull-resistor-disable bit switches off.
package jtp_pkg;

    // ************************************************************
    // instruction and data register layout
    // ************************************************************
    localparam int JTP_IR_W = 4;
    localparam logic [JTP_IR_W-1:0] JTP_IR_CAPTURE = 4'h1;
    localparam logic [JTP_IR_W-1:0] JTP_INST_IDCODE = 4'h2;
    localparam logic [JTP_IR_W-1:0] JTP_INST_DATA = 4'h8;
    localparam logic [JTP_IR_W-1:0] JTP_INST_BYPASS = 4'hf;
    localparam int JTP_DR_W = 32;
    localparam int JTP_DATA_W = 8;
    localparam int JTP_FIFO_DEPTH = 32;
    // arbitrary identification value, lsb set as the test port demands
    localparam logic [JTP_DR_W-1:0] JTP_IDCODE_DEFAULT = 32'h0000_0001;
    localparam logic [2:0] JTP_TMS_RESET_RUN = 3'h5;

    // ************************************************************
    // TAP controller states, one-hot
    // ************************************************************
    typedef enum logic [15:0] {
        JTP_TLR  = 16'h0001,
        JTP_RTI  = 16'h0002,
        JTP_SDS  = 16'h0004,
        JTP_CDR  = 16'h0008,
        JTP_SHDR = 16'h0010,
        JTP_E1DR = 16'h0020,
        JTP_PDR  = 16'h0040,
        JTP_E2DR = 16'h0080,
        JTP_UDR  = 16'h0100,
        JTP_SIS  = 16'h0200,
        JTP_CIR  = 16'h0400,
        JTP_SHIR = 16'h0800,
        JTP_E1IR = 16'h1000,
        JTP_PIR  = 16'h2000,
        JTP_E2IR = 16'h4000,
        JTP_UIR  = 16'h8000
    } jtp_tap_t;

endpackage : jtp_pkg

// >>> rtl/jtp_fifo.sv
// small fifo with a registered output stage
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
module jtp_fifo #(
    parameter int W = 8,
    parameter int D = 32
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [W-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [W-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(D);

    // refuse depths the pointer logic cannot serve
    if (D < 2 || W < 1) begin : g_chk
        $error("jtp_fifo: depth must be at least 2");
    end

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic [W-1:0] dout;
        logic dval;
    } jtp_fifo_state_t;

    jtp_fifo_state_t st_ff;
    jtp_fifo_state_t nxt_st;
    logic wr;
    logic load;

    // ************************************************************
    // pointer, count and output stage
    // ************************************************************
    assign in_ready = (st_ff.cnt != (AW+1)'(D));
    assign out_data = st_ff.dout;
    assign out_valid = st_ff.dval;
    assign wr = in_valid && in_ready;
    assign load = (st_ff.cnt != '0) && (!st_ff.dval || out_ready);

    // next state of the whole fifo
    always_comb begin
        nxt_st = st_ff;
        if (st_ff.dval && out_ready) begin
            nxt_st.dval = 1'b0;
        end
        if (load) begin
            nxt_st.dout = st_ff.mem[st_ff.rp];
            nxt_st.dval = 1'b1;
            nxt_st.rp = (st_ff.rp == AW'(D-1)) ? '0 : st_ff.rp + 1'b1;
        end
        if (wr) begin
            nxt_st.mem[st_ff.wp] = in_data;
            nxt_st.wp = (st_ff.wp == AW'(D-1)) ? '0 : st_ff.wp + 1'b1;
        end
        nxt_st.cnt = st_ff.cnt + {{AW{1'b0}}, wr} - {{AW{1'b0}}, load};
        if (!rstn) begin
            nxt_st.wp = '0;
            nxt_st.rp = '0;
            nxt_st.cnt = '0;
            nxt_st.dval = 1'b0;
        end
    end

    // state register
    always_ff @(posedge sys_clk) begin
        st_ff <= nxt_st;
    end

    a_fifo_count: assert property (@(posedge sys_clk) disable iff (!rstn)
        st_ff.cnt <= (AW+1)'(D))
        else $error("fifo count above depth");

endmodule : jtp_fifo

// >>> rtl/jtp_port.sv
// boundary test port: TAP controller, instruction and data registers
// assumes tck, tms, tdi and trst_n arrive asynchronously from a probe and
// that sys_clk runs at least eight times the test clock rate
`timescale 1ns/1ps
module jtp_port #(
    parameter logic [jtp_pkg::JTP_DR_W-1:0] IDCODE =
        jtp_pkg::JTP_IDCODE_DEFAULT,
    parameter int FIFO_DEPTH = jtp_pkg::JTP_FIFO_DEPTH
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic trst_n,
    output logic tdo_o,
    output logic tdo_oe,
    input wire logic pull_resistor_disable_jtag,
    output logic tck_pulldown_en,
    output logic tms_pullup_en,
    output logic tdi_pullup_en,
    output logic trst_pullup_en,
    output logic [jtp_pkg::JTP_DATA_W-1:0] rx_data,
    output logic rx_valid,
    input wire logic rx_ready
);
    localparam int IRW = jtp_pkg::JTP_IR_W;
    localparam int DRW = jtp_pkg::JTP_DR_W;
    localparam int DW = jtp_pkg::JTP_DATA_W;

    // refuse depths the buffer cannot serve
    if (FIFO_DEPTH < 2) begin : g_chk
        $error("jtp_port: fifo depth must be at least 2");
    end

    typedef struct packed {
        logic [2:0] tck_sh;
        logic [1:0] tms_sh;
        logic [1:0] tdi_sh;
        logic [1:0] trst_sh;
        jtp_pkg::jtp_tap_t tap;
        logic [IRW-1:0] ir_sr;
        logic [IRW-1:0] ir;
        logic [DRW-1:0] dr_sr;
        logic tdo;
        logic oe;
        logic push;
        logic [DW-1:0] push_data;
        logic [2:0] tms_run;
    } jtp_state_t;

    jtp_state_t st_ff;
    jtp_state_t nxt_st;
    logic tck_rise;
    logic tck_fall;
    logic tms_s;
    logic tdi_s;
    logic trst_s;
    logic push_ready;
    logic in_shift;

    // ************************************************************
    // TAP transition table
    // ************************************************************
    function automatic jtp_pkg::jtp_tap_t tap_next(
        input jtp_pkg::jtp_tap_t s,
        input logic m
    );
        unique case (s)
            jtp_pkg::JTP_TLR:
                tap_next = m ? jtp_pkg::JTP_TLR : jtp_pkg::JTP_RTI;
            jtp_pkg::JTP_RTI:
                tap_next = m ? jtp_pkg::JTP_SDS : jtp_pkg::JTP_RTI;
            jtp_pkg::JTP_SDS:
                tap_next = m ? jtp_pkg::JTP_SIS : jtp_pkg::JTP_CDR;
            jtp_pkg::JTP_CDR:
                tap_next = m ? jtp_pkg::JTP_E1DR : jtp_pkg::JTP_SHDR;
            jtp_pkg::JTP_SHDR:
                tap_next = m ? jtp_pkg::JTP_E1DR : jtp_pkg::JTP_SHDR;
            jtp_pkg::JTP_E1DR:
                tap_next = m ? jtp_pkg::JTP_UDR : jtp_pkg::JTP_PDR;
            jtp_pkg::JTP_PDR:
                tap_next = m ? jtp_pkg::JTP_E2DR : jtp_pkg::JTP_PDR;
            jtp_pkg::JTP_E2DR:
                tap_next = m ? jtp_pkg::JTP_UDR : jtp_pkg::JTP_SHDR;
            jtp_pkg::JTP_UDR:
                tap_next = m ? jtp_pkg::JTP_SDS : jtp_pkg::JTP_RTI;
            jtp_pkg::JTP_SIS:
                tap_next = m ? jtp_pkg::JTP_TLR : jtp_pkg::JTP_CIR;
            jtp_pkg::JTP_CIR:
                tap_next = m ? jtp_pkg::JTP_E1IR : jtp_pkg::JTP_SHIR;
            jtp_pkg::JTP_SHIR:
                tap_next = m ? jtp_pkg::JTP_E1IR : jtp_pkg::JTP_SHIR;
            jtp_pkg::JTP_E1IR:
                tap_next = m ? jtp_pkg::JTP_UIR : jtp_pkg::JTP_PIR;
            jtp_pkg::JTP_PIR:
                tap_next = m ? jtp_pkg::JTP_E2IR : jtp_pkg::JTP_PIR;
            jtp_pkg::JTP_E2IR:
                tap_next = m ? jtp_pkg::JTP_UIR : jtp_pkg::JTP_SHIR;
            jtp_pkg::JTP_UIR:
                tap_next = m ? jtp_pkg::JTP_SDS : jtp_pkg::JTP_RTI;
            default: tap_next = jtp_pkg::JTP_TLR; // illegal code
        endcase
    endfunction : tap_next

    // ************************************************************
    // sampled pins and edge detection
    // ************************************************************
    assign tck_rise = st_ff.tck_sh[1] && !st_ff.tck_sh[2];
    assign tck_fall = !st_ff.tck_sh[1] && st_ff.tck_sh[2];
    assign tms_s = st_ff.tms_sh[1];
    assign tdi_s = st_ff.tdi_sh[1];
    assign trst_s = st_ff.trst_sh[1];
    assign in_shift = (st_ff.tap == jtp_pkg::JTP_SHIR) ||
                      (st_ff.tap == jtp_pkg::JTP_SHDR);

    // pad pulls and the serial output
    assign tck_pulldown_en = 1'b1;
    assign tms_pullup_en = !pull_resistor_disable_jtag;
    assign tdi_pullup_en = !pull_resistor_disable_jtag;
    assign trst_pullup_en = !pull_resistor_disable_jtag;
    assign tdo_o = st_ff.tdo;
    assign tdo_oe = st_ff.oe;

    // ************************************************************
    // next state of the port
    // ************************************************************
    always_comb begin
        nxt_st = st_ff;
        nxt_st.tck_sh = {st_ff.tck_sh[1:0], tck};
        nxt_st.tms_sh = {st_ff.tms_sh[0], tms};
        nxt_st.tdi_sh = {st_ff.tdi_sh[0], tdi};
        nxt_st.trst_sh = {st_ff.trst_sh[0], trst_n};
        nxt_st.push = 1'b0;
        // work only on a test clock rise
        if (tck_rise) begin
            nxt_st.tap = tap_next(st_ff.tap, tms_s);
            if (!tms_s) begin
                nxt_st.tms_run = '0;
            end else if (st_ff.tms_run != jtp_pkg::JTP_TMS_RESET_RUN) begin
                nxt_st.tms_run = st_ff.tms_run + 3'h1;
            end
            unique case (st_ff.tap)
                jtp_pkg::JTP_TLR: nxt_st.ir = jtp_pkg::JTP_INST_IDCODE;
                jtp_pkg::JTP_CIR: nxt_st.ir_sr = jtp_pkg::JTP_IR_CAPTURE;
                jtp_pkg::JTP_SHIR: begin
                    nxt_st.ir_sr = {tdi_s, st_ff.ir_sr[IRW-1:1]};
                end
                jtp_pkg::JTP_UIR: nxt_st.ir = st_ff.ir_sr;
                jtp_pkg::JTP_CDR: begin
                    if (st_ff.ir == jtp_pkg::JTP_INST_IDCODE) begin
                        nxt_st.dr_sr = IDCODE;
                    end else if (st_ff.ir == jtp_pkg::JTP_INST_DATA) begin
                        nxt_st.dr_sr = {{(DRW-1){1'b0}}, push_ready};
                    end else begin
                        nxt_st.dr_sr = '0;
                    end
                end
                jtp_pkg::JTP_SHDR: begin
                    // shift length follows the instruction
                    if (st_ff.ir == jtp_pkg::JTP_INST_IDCODE) begin
                        nxt_st.dr_sr = {tdi_s, st_ff.dr_sr[DRW-1:1]};
                    end else if (st_ff.ir == jtp_pkg::JTP_INST_DATA) begin
                        nxt_st.dr_sr = {{(DRW-DW){1'b0}}, tdi_s,
                                        st_ff.dr_sr[DW-1:1]};
                    end else begin
                        nxt_st.dr_sr = {{(DRW-1){1'b0}}, tdi_s};
                    end
                end
                jtp_pkg::JTP_UDR: begin
                    // word handed to the core; dropped if the buffer is full
                    if (st_ff.ir == jtp_pkg::JTP_INST_DATA && push_ready) begin
                        nxt_st.push = 1'b1;
                        nxt_st.push_data = st_ff.dr_sr[DW-1:0];
                    end
                end
                default: ;
            endcase
        end
        // output changes only on the fall or under a low test reset
        if (tck_fall) begin
            nxt_st.oe = in_shift;
            nxt_st.tdo = (st_ff.tap == jtp_pkg::JTP_SHIR) ?
                         st_ff.ir_sr[0] : st_ff.dr_sr[0];
        end
        // test reset hits only the TAP side
        if (!trst_s) begin
            nxt_st.tap = jtp_pkg::JTP_TLR;
            nxt_st.ir = jtp_pkg::JTP_INST_IDCODE;
            nxt_st.oe = 1'b0;
            nxt_st.tdo = 1'b0;
            nxt_st.tms_run = '0;
            // shift registers cleared so no unknown survives into a scan
            nxt_st.ir_sr = '0;
            nxt_st.dr_sr = '0;
        end
        // system reset clears only the core handoff, not the TAP
        if (!rstn) begin
            nxt_st.push = 1'b0;
        end
    end

    // state register
    always_ff @(posedge sys_clk) begin
        st_ff <= nxt_st;
    end

    // ************************************************************
    // buffer toward the core
    // ************************************************************
    jtp_fifo #(
        .W(DW),
        .D(FIFO_DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .in_data(st_ff.push_data),
        .in_valid(st_ff.push),
        .in_ready(push_ready),
        .out_data(rx_data),
        .out_valid(rx_valid),
        .out_ready(rx_ready)
    );

    // ************************************************************
    // checks
    // ************************************************************
    a_oe_in_shift: assert property (@(posedge sys_clk)
        disable iff (!rstn) tck_fall && trst_s && in_shift |=> tdo_oe)
        else $error("tdo not driven in shift state");

    a_hiz_outside: assert property (@(posedge sys_clk)
        disable iff (!rstn) tck_fall && !in_shift |=> !tdo_oe)
        else $error("tdo driven outside shift state");

    a_tdo_on_fall: assert property (@(posedge sys_clk)
        disable iff (!rstn)
        !tck_fall && trst_s |=> $stable(tdo_o) && $stable(tdo_oe))
        else $error("tdo changed away from falling edge");

    a_trst_reset: assert property (@(posedge sys_clk) disable iff (!rstn)
        !trst_s |=> st_ff.tap == jtp_pkg::JTP_TLR && !tdo_oe)
        else $error("test reset did not reset tap");

    a_tap_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
        !tck_rise && trst_s |=> $stable(st_ff.tap) && $stable(st_ff.dr_sr))
        else $error("tap moved without test clock rise");

    a_tms_step: assert property (@(posedge sys_clk) disable iff (!rstn)
        tck_rise && trst_s && st_ff.tap == jtp_pkg::JTP_RTI && tms_s
        |=> st_ff.tap == jtp_pkg::JTP_SDS)
        else $error("tms high in idle did not select dr scan");

    a_ir_shift_in: assert property (@(posedge sys_clk)
        disable iff (!rstn)
        tck_rise && trst_s && st_ff.tap == jtp_pkg::JTP_SHIR
        |=> st_ff.ir_sr[IRW-1] == $past(tdi_s))
        else $error("tdi not shifted into instruction register");

    a_five_tms: assert property (@(posedge sys_clk) disable iff (!rstn)
        tck_rise && tms_s &&
        st_ff.tms_run == jtp_pkg::JTP_TMS_RESET_RUN - 3'h1
        |=> st_ff.tap == jtp_pkg::JTP_TLR)
        else $error("five tms highs did not reach test logic reset");

    a_pull_ctrl: assert property (@(posedge sys_clk) disable iff (!rstn)
        tms_pullup_en != pull_resistor_disable_jtag && tck_pulldown_en)
        else $error("pull control wrong");

    a_push_ready: assert property (@(posedge sys_clk) disable iff (!rstn)
        st_ff.push |-> push_ready)
        else $error("push into full buffer");

endmodule : jtp_port

// >>> bench/jtp_probe.sv
// behavioural test probe driving the boundary test port pins
// assumes the bench resolves the tdo line from data and enable
`timescale 1ns/1ps
module jtp_probe (
    output logic tck,
    output logic tms,
    output logic tdi,
    output logic trst_n,
    input wire logic tdo,
    input wire logic tdo_oe,
    output logic [7:0] moved_cnt
);
    // ****
    // idle pins
    // ****
    // clock parked low between frames, test reset held low, tms and tdi at their pull level
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
        trst_n = 1'b0;
        moved_cnt = 8'h00;
    end

    // ****
    // frame tasks
    // ****
    // one 64 ns test clock period, tdo taken at rise, rechecked before fall
    task automatic tick(input logic m, input logic d, output logic q,
                        output logic oe);
        tms = m;
        tdi = d;
        #32;
        tck = 1'b1;
        q = tdo;
        oe = tdo_oe;
        #31;
        if (tdo !== q) moved_cnt = moved_cnt + 8'h01;
        #1;
        tck = 1'b0;
    endtask : tick

    // walk the state machine with mode select bits, lsb first
    task automatic walk(input logic [7:0] m, input int n);
        logic q;
        logic oe;
        for (int i = 0; i < n; i++) tick(m[i], 1'b1, q, oe);
    endtask : walk

    // full ir or dr scan from idle back to idle, lsb first
    task automatic scan(input logic ir, input int n, input logic [31:0] v,
                        output logic [31:0] o, output logic oe_all);
        logic q;
        logic oe;
        o = 32'h0000_0000;
        oe_all = 1'b1;
        walk(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, v[i], q, oe);
            o[i] = q;
            oe_all = oe_all & oe;
        end
        walk(8'h01, 2);
    endtask : scan

    // test reset pulse, then the settling gap before the next rise
    task automatic reset_pulse();
        trst_n = 1'b0;
        #64;
        trst_n = 1'b1;
        #64;
    endtask : reset_pulse
endmodule : jtp_probe

// >>> bench/test_jtag_test_port_pins.sv
// self-checking bench of the boundary test port
// assumes jtp_probe as the far side and a 125 MHz system clock
`timescale 1ns/1ps
module test_jtag_test_port_pins;
    localparam logic [31:0] ID = 32'h0c3a_5e71; // arbitrary value
    localparam int DEPTH = 4;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic rx_ready = 1'b0;
    logic pud = 1'b0;
    logic tck, tms, tdi, trst_n, tdo_o, tdo_oe, tdo_pin;
    logic tdo_last = 1'b0;
    logic tck_pulldown_en, tms_pullup_en, tdi_pullup_en, trst_pullup_en;
    logic [2:0] pulls;
    logic [7:0] rx_data;
    logic [7:0] moved_cnt;
    logic rx_valid;
    logic [31:0] o;
    logic oe;
    int fails = 0;
    int cmp_count = 0;
    int cyc = 0;

    // ****
    // clock, pin and instances
    // ****
    always #4 sys_clk = ~sys_clk;
    // released tdo line shows the inverse of its last driven value
    always @(tdo_o or tdo_oe) if (tdo_oe) tdo_last = tdo_o;
    assign tdo_pin = tdo_oe ? tdo_o : ~tdo_last;
    assign pulls = {tms_pullup_en, tdi_pullup_en, trst_pullup_en};

    jtp_port #(.IDCODE(ID), .FIFO_DEPTH(DEPTH)) uut (
        .sys_clk(sys_clk), .rstn(rstn), .tck(tck), .tms(tms), .tdi(tdi),
        .trst_n(trst_n), .tdo_o(tdo_o), .tdo_oe(tdo_oe),
        .pull_resistor_disable_jtag(pud),
        .tck_pulldown_en(tck_pulldown_en), .tms_pullup_en(tms_pullup_en),
        .tdi_pullup_en(tdi_pullup_en), .trst_pullup_en(trst_pullup_en),
        .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready));

    jtp_probe probe (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
        .tdo(tdo_pin), .tdo_oe(tdo_oe), .moved_cnt(moved_cnt));

    // ****
    // helpers
    // ****
    task automatic step();
        @(posedge sys_clk);
        #1;
    endtask : step

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string msg);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %0t %s: %h vs %h", $time, msg, seen, exp);
        end
    endtask : check

    // wait for a word, compare it, then take it with one ready cycle
    task automatic take(input logic [7:0] exp);
        for (int n = 0; n < 20 && rx_valid !== 1'b1; n++) step();
        check(rx_valid, 1'b1, "word ready");
        check(rx_data, exp, "word data");
        rx_ready = 1'b1;
        step();
        rx_ready = 1'b0;
    endtask : take

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop

    // ****
    // scenarios
    // ****
    task automatic t_pins();
        check(tdo_oe, 1'b0, "tdo after reset");
        check(tck_pulldown_en, 1'b1, "tck pull");
        check(pulls, 3'h7, "pulls on");
        pud = 1'b1;
        step();
        check(pulls, 3'h0, "pulls off");
        pud = 1'b0;
        $display("test pins done");
    endtask : t_pins

    task automatic t_scans();
        probe.walk(8'h1f, 6);
        probe.scan(1'b0, 32, 32'h0000_0000, o, oe);
        check(o, ID, "id read");
        check(oe, 1'b1, "drive in shift");
        check(tdo_oe, 1'b0, "idle release");
        probe.scan(1'b1, 4, {28'h0, jtp_pkg::JTP_INST_BYPASS}, o, oe);
        check(o[3:0], jtp_pkg::JTP_IR_CAPTURE, "ir capture");
        probe.scan(1'b0, 2, 32'h0000_0001, o, oe);
        check(o[1:0], 2'h2, "bypass");
        $display("test scans done");
    endtask : t_scans

    // fill the buffer with the consumer stalled, then drain in order
    task automatic t_stream();
        probe.scan(1'b1, 4, {28'h0, jtp_pkg::JTP_INST_DATA}, o, oe);
        for (int k = 0; k <= DEPTH + 1; k++) begin
            probe.scan(1'b0, 8, 32'h0000_00a0 + k, o, oe);
            check(o[0], k <= DEPTH, "not full bit");
        end
        for (int k = 0; k <= DEPTH; k++) take(8'ha0 + k[7:0]);
        repeat (4) step();
        check(rx_valid, 1'b0, "drop when full");
        $display("test stream done");
    endtask : t_stream

    // system reset alone keeps the data instruction selected
    task automatic t_sysreset();
        probe.scan(1'b0, 8, 32'h0000_0033, o, oe);
        repeat (4) step();
        check(rx_valid, 1'b1, "word held");
        rstn = 1'b0;
        step();
        step();
        rstn = 1'b1;
        check(rx_valid, 1'b0, "buffer emptied");
        probe.scan(1'b0, 8, 32'h0000_005d, o, oe);
        take(8'h5d);
        $display("test system reset done");
    endtask : t_sysreset

    task automatic t_tapreset();
        probe.walk(8'h1f, 6);
        probe.scan(1'b0, 32, 32'h0000_0000, o, oe);
        check(o, ID, "five ones reset");
        probe.scan(1'b1, 4, {28'h0, jtp_pkg::JTP_INST_DATA}, o, oe);
        probe.walk(8'h01, 3);
        repeat (4) step();
        check(tdo_oe, 1'b1, "drive in shift-dr");
        probe.reset_pulse();
        check(tdo_oe, 1'b0, "tdo in reset");
        probe.walk(8'h00, 1);
        probe.scan(1'b0, 32, 32'h0000_0000, o, oe);
        check(o, ID, "test reset");
        check(moved_cnt, 8'h00, "tdo only moves at fall");
        $display("test tap reset done");
    endtask : t_tapreset

    // ****
    // main sequence and watchdog
    // ****
    initial begin
        repeat (20) step();
        rstn = 1'b1;
        probe.reset_pulse();
        t_pins();
        t_scans();
        t_stream();
        t_sysreset();
        t_tapreset();
        report_and_stop();
    end

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            fails++;
            report_and_stop();
        end
    end
endmodule : test_jtag_test_port_pins
